// ==== hw/rsr_pkg.sv ====
// Package with register map, field positions and reset values
package rsr_pkg;
   // Register indices, one 32-bit word each
   localparam logic [7:0] IDX_CRC_IRQ_FIFO_STATUS = 8'h07;
   localparam logic [7:0] IDX_MODEM_TEMP_CIPHER_STATUS = 8'h08;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
   localparam logic [7:0] IDX_FIFO_THRESHOLD = 8'h12;
   // Byte addresses are four times the register index
   localparam logic [11:0] ADDR_CRC_IRQ_FIFO_STATUS =
      {2'b00, IDX_CRC_IRQ_FIFO_STATUS, 2'b00};
   localparam logic [11:0] ADDR_MODEM_TEMP_CIPHER_STATUS =
      {2'b00, IDX_MODEM_TEMP_CIPHER_STATUS, 2'b00};
   localparam logic [11:0] ADDR_IRQ_STATUS =
      {2'b00, IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] ADDR_IRQ_MASK =
      {2'b00, IDX_IRQ_MASK, 2'b00};
   localparam logic [11:0] ADDR_FIFO_THRESHOLD =
      {2'b00, IDX_FIFO_THRESHOLD, 2'b00};
   // Reset values
   localparam logic [7:0] RST_CRC_IRQ_FIFO_STATUS = 8'h21;
   localparam logic [7:0] RST_MODEM_TEMP_CIPHER_STATUS = 8'h00;
   localparam logic [6:0] RST_FIFO_THRESHOLD = 7'h08;
   // First status register fields
   localparam int BIT_CRC_RESULT_ZERO = 6;
   localparam int BIT_CRC_CALC_DONE = 5;
   localparam int BIT_IRQ_PENDING = 4;
   localparam int BIT_TIMER_ACTIVE = 3;
   localparam int BIT_FIFO_HIGH_ALERT = 1;
   localparam int BIT_FIFO_LOW_ALERT = 0;
   // Second status register fields
   localparam int BIT_OVERHEAT_ERROR_CLEAR = 7;
   localparam int BIT_HOST_FILTER_HS_FORCE = 6;
   localparam int BIT_CARD_CIPHER_ACTIVE = 3;
   localparam int LSB_TXRX_STATE = 0;
   // FIFO capacity in bytes
   localparam logic [6:0] FIFO_CAPACITY = 7'h40;
   // Event status bits
   localparam int EVT_CRC_DONE = 0;
   localparam int EVT_OVERHEAT = 1;
   localparam int EVT_HIGH_ALERT = 2;
   localparam int EVT_LOW_ALERT = 3;
   localparam int EVT_COUNT = 4;
   // Transmitter/receiver state codes
   typedef enum logic [2:0] {
      TXRX_IDLE = 3'h0,
      TXRX_AWAIT_SEND = 3'h1,
      TXRX_TX_WAIT = 3'h2,
      TXRX_TRANSMIT = 3'h3,
      TXRX_RX_WAIT = 3'h4,
      TXRX_WAIT_DATA = 3'h5,
      TXRX_RECEIVE = 3'h6
   } rsr_txrx_e;
endpackage

// ==== hw/rsr_status_regs.sv ====
// Reader status register bank with APB slave and event interrupt
`timescale 1ns/1ns
module rsr_status_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic crcBusy,
   input wire logic crcResultZero,
   input wire logic crcStandaloneDone,
   input wire logic crcStandaloneStart,
   input wire logic [13:0] irqSources,
   input wire logic [13:0] irqEnables,
   input wire logic timerCounting,
   input wire logic timerGatedMode,
   input wire logic timerGateEnabled,
   input wire logic [6:0] fifoByteCount,
   input wire logic overheatDetect,
   input wire logic belowAlarmLimit,
   input wire logic authSuccess,
   input wire logic [2:0] txrxStateCode,
   output logic antennaDriversOff,
   output logic hostFilterHighspeedForce,
   output logic cardCipherActive,
   output logic irq
);

   // Pin-domain inputs pass two flip-flops
   logic overheatMeta;
   logic overheatSync;
   logic belowMeta;
   logic belowSync;

   // Status state
   logic crcDone;
   logic next_crcDone;
   logic overheatError;
   logic next_overheatError;
   logic cipherOn;
   logic next_cipherOn;
   logic filterForce;
   logic next_filterForce;
   logic [6:0] alertLevel;
   logic [6:0] next_alertLevel;
   logic [rsr_pkg::EVT_COUNT-1:0] evtStatus;
   logic [rsr_pkg::EVT_COUNT-1:0] next_evtStatus;
   logic [rsr_pkg::EVT_COUNT-1:0] evtMask;
   logic [rsr_pkg::EVT_COUNT-1:0] next_evtMask;
   logic [rsr_pkg::EVT_COUNT-1:0] evtPrev;
   logic [7:0] status1;
   logic [7:0] status2;
   logic [7:0] next_status1;
   logic [7:0] next_status2;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic [rsr_pkg::EVT_COUNT-1:0] evtNow;
   logic highAlert;
   logic lowAlert;
   logic timerFlag;
   logic wrStrobe;
   logic wrStatus2;
   logic [6:0] freeBytes;
   logic wrThreshold;
   logic wrMask;
   logic wrEvents;
   logic [rsr_pkg::EVT_COUNT-1:0] evtRise;
   logic evtArmed;

   // Decode whether an address is mapped
   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == rsr_pkg::ADDR_CRC_IRQ_FIFO_STATUS) ||
         (a == rsr_pkg::ADDR_MODEM_TEMP_CIPHER_STATUS) ||
         (a == rsr_pkg::ADDR_IRQ_STATUS) ||
         (a == rsr_pkg::ADDR_IRQ_MASK) ||
         (a == rsr_pkg::ADDR_FIFO_THRESHOLD);
   endfunction

   // Synchronisers for temperature sensor levels
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overheatMeta <= 1'b0;
         overheatSync <= 1'b0;
         belowMeta <= 1'b0;
         belowSync <= 1'b0;
      end else begin
         overheatMeta <= overheatDetect;
         overheatSync <= overheatMeta;
         belowMeta <= belowAlarmLimit;
         belowSync <= belowMeta;
      end
   end

   // Live comparisons and flag sources
   always_comb begin
      freeBytes = 7'(rsr_pkg::FIFO_CAPACITY - fifoByteCount);
      highAlert = (freeBytes <= alertLevel);
      lowAlert = (fifoByteCount <= alertLevel);
      // Gated mode reports the select, not the gate level
      timerFlag = timerGatedMode ? timerGateEnabled
                                 : timerCounting;
      wrStrobe = psel && penable && pwrite;
      wrStatus2 = wrStrobe &&
         (paddr == rsr_pkg::ADDR_MODEM_TEMP_CIPHER_STATUS);
      wrThreshold = wrStrobe &&
         (paddr == rsr_pkg::ADDR_FIFO_THRESHOLD);
      wrMask = wrStrobe && (paddr == rsr_pkg::ADDR_IRQ_MASK);
      wrEvents = wrStrobe && (paddr == rsr_pkg::ADDR_IRQ_STATUS);
      evtNow = '0;
      evtNow[rsr_pkg::EVT_CRC_DONE] = crcDone;
      evtNow[rsr_pkg::EVT_OVERHEAT] = overheatError;
      evtNow[rsr_pkg::EVT_HIGH_ALERT] = highAlert;
      evtNow[rsr_pkg::EVT_LOW_ALERT] = lowAlert;
   end

   // Standalone CRC done flag: a start clears it, the finish sets it
   always_comb begin
      next_crcDone = crcDone;
      if (crcStandaloneStart) begin
         next_crcDone = 1'b0;
      end
      if (crcStandaloneDone) begin
         next_crcDone = 1'b1;
      end
   end

   // Done flag leaves reset set, so the image matches its reset value
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crcDone <=
            rsr_pkg::RST_CRC_IRQ_FIFO_STATUS[rsr_pkg::BIT_CRC_CALC_DONE];
      end else begin
         crcDone <= next_crcDone;
      end
   end

   // Overheat error: sensor sets, software clears only when cool
   always_comb begin
      next_overheatError = overheatError;
      if (wrStatus2 && pwdata[rsr_pkg::BIT_OVERHEAT_ERROR_CLEAR] &&
          belowSync) begin
         next_overheatError = 1'b0;
      end
      // Detection wins over a clear in the same cycle
      if (overheatSync) begin
         next_overheatError = 1'b1;
      end
   end

   // Overheat error register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overheatError <= 1'b0;
      end else begin
         overheatError <= next_overheatError;
      end
   end

   // Cipher flag and host filter override
   always_comb begin
      next_cipherOn = cipherOn;
      // Writing zero to the cipher bit switches encryption off
      if (wrStatus2 && !pwdata[rsr_pkg::BIT_CARD_CIPHER_ACTIVE]) begin
         next_cipherOn = 1'b0;
      end
      // A completed authentication wins over a clear
      if (authSuccess) begin
         next_cipherOn = 1'b1;
      end
      next_filterForce = filterForce;
      if (wrStatus2) begin
         next_filterForce = pwdata[rsr_pkg::BIT_HOST_FILTER_HS_FORCE];
      end
   end

   // Cipher and filter registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cipherOn <= 1'b0;
         filterForce <= 1'b0;
      end else begin
         cipherOn <= next_cipherOn;
         filterForce <= next_filterForce;
      end
   end

   // Alert threshold and event mask, written by software
   always_comb begin
      next_alertLevel = alertLevel;
      if (wrThreshold) begin
         next_alertLevel = pwdata[6:0];
      end
      next_evtMask = evtMask;
      if (wrMask) begin
         next_evtMask = pwdata[rsr_pkg::EVT_COUNT-1:0];
      end
   end

   // Configuration registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alertLevel <= rsr_pkg::RST_FIFO_THRESHOLD;
         evtMask <= '0;
      end else begin
         alertLevel <= next_alertLevel;
         evtMask <= next_evtMask;
      end
   end

   // Sticky event bits; a rising event wins over a write-one clear
   always_comb begin
      // No edge is taken before the history holds a real sample
      evtRise = '0;
      if (evtArmed) begin
         evtRise = evtNow & ~evtPrev;
      end
      next_evtStatus = evtStatus;
      if (wrEvents) begin
         next_evtStatus = evtStatus & ~pwdata[rsr_pkg::EVT_COUNT-1:0];
      end
      next_evtStatus = next_evtStatus | evtRise;
      next_irq = |(next_evtStatus & next_evtMask);
   end

   // Event status and edge history
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         evtStatus <= '0;
         evtPrev <= '0;
         evtArmed <= 1'b0;
      end else begin
         evtStatus <= next_evtStatus;
         evtPrev <= evtNow;
         evtArmed <= 1'b1;
      end
   end

   // Register image assembly
   always_comb begin
      next_status1 = '0;
      // Calculation in progress forces zero; value is don't-care in RF
      next_status1[rsr_pkg::BIT_CRC_RESULT_ZERO] =
         !crcBusy && crcResultZero;
      next_status1[rsr_pkg::BIT_CRC_CALC_DONE] = next_crcDone;
      next_status1[rsr_pkg::BIT_IRQ_PENDING] =
         |(irqSources & irqEnables);
      next_status1[rsr_pkg::BIT_TIMER_ACTIVE] = timerFlag;
      next_status1[rsr_pkg::BIT_FIFO_HIGH_ALERT] = highAlert;
      next_status1[rsr_pkg::BIT_FIFO_LOW_ALERT] = lowAlert;
      next_status2 = '0;
      next_status2[rsr_pkg::BIT_OVERHEAT_ERROR_CLEAR] = 1'b0;
      next_status2[rsr_pkg::BIT_HOST_FILTER_HS_FORCE] = next_filterForce;
      next_status2[rsr_pkg::BIT_CARD_CIPHER_ACTIVE] = next_cipherOn;
      next_status2[rsr_pkg::LSB_TXRX_STATE +: 3] =
         txrxStateCode;
   end

   // APB answer: zero wait states, error on unmapped address
   always_comb begin
      next_pready = psel && !penable;
      next_pslverr = psel && !penable && !isMapped(paddr);
      next_prdata = '0;
      if (psel && !penable && !pwrite) begin
         // Reads only select data, they change no state
         unique case (paddr)
            rsr_pkg::ADDR_CRC_IRQ_FIFO_STATUS:
               next_prdata = {24'h000000, status1};
            rsr_pkg::ADDR_MODEM_TEMP_CIPHER_STATUS:
               next_prdata = {24'h000000, status2};
            rsr_pkg::ADDR_IRQ_STATUS:
               next_prdata = {28'h0000000, evtStatus};
            rsr_pkg::ADDR_IRQ_MASK:
               next_prdata = {28'h0000000, evtMask};
            rsr_pkg::ADDR_FIFO_THRESHOLD:
               next_prdata = {25'h0000000, alertLevel};
            default:
               next_prdata = '0;
         endcase
      end
   end

   // Status register images
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status1 <= rsr_pkg::RST_CRC_IRQ_FIFO_STATUS;
         status2 <= rsr_pkg::RST_MODEM_TEMP_CIPHER_STATUS;
      end else begin
         status1 <= next_status1;
         status2 <= next_status2;
      end
   end

   // Bus answer registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Top-level side outputs, each straight from a flip-flop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
         antennaDriversOff <= 1'b0;
         hostFilterHighspeedForce <= 1'b0;
         cardCipherActive <= 1'b0;
      end else begin
         irq <= next_irq;
         antennaDriversOff <= next_overheatError;
         hostFilterHighspeedForce <= next_filterForce;
         cardCipherActive <= next_cipherOn;
      end
   end

endmodule

// ==== test/rsr_status_regs_assertions.sv ====
// Port-level checks of the reader status register bank
`timescale 1ns/1ns
module rsr_status_regs_assertions (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crcBusy,
   input wire logic overheatDetect,
   input wire logic authSuccess,
   input wire logic antennaDriversOff,
   input wire logic hostFilterHighspeedForce,
   input wire logic cardCipherActive
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Bus answer timing and refusal
   access_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   refuse_zero_a: assert property (
      pslverr |-> pready && prdata == 32'h0)
      else $error("refused access returned data");
   mapped_ok_a: assert property (
      pready && (paddr == 12'h01C || paddr == 12'h020)
      |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("status register access refused");
   // Flag stays low while the engine is busy
   crc_busy_low_a: assert property (
      pready && !pwrite && paddr == 12'h01C &&
      $past(crcBusy) && $past(crcBusy, 2) && $past(crcBusy, 3)
      |-> !prdata[6])
      else $error("result flag high while busy");
   // Two synchroniser stages plus the drivers-off output flop give the latency
   overheat_off_a: assert property (
      overheatDetect[*4] |-> antennaDriversOff)
      else $error("drivers not off on overheat");
   filter_write_a: assert property (
      psel && penable && pwrite && pready && paddr == 12'h020
      |=> hostFilterHighspeedForce == $past(pwdata[6]))
      else $error("filter force not written");
   cipher_set_a: assert property (
      authSuccess |-> ##[1:2] cardCipherActive)
      else $error("cipher flag not set");
   cipher_cause_a: assert property (
      $rose(cardCipherActive) |-> $past(authSuccess) || $past(authSuccess, 2))
      else $error("cipher flag set without authentication");
   cover property (pready && pslverr);
   cover property (authSuccess ##1 cardCipherActive);
   cover property (overheatDetect[*4] ##1 antennaDriversOff);
endmodule

// ==== test/rsr_status_regs_tb_top.sv ====
// Self-checking bench for the reader status register bank
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin badCount++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module rsr_status_regs_tb_top;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic crcBusy, crcResultZero, crcStandaloneDone, crcStandaloneStart;
   logic [13:0] irqSources, irqEnables;
   logic timerCounting, timerGatedMode, timerGateEnabled, overheatDetect;
   logic belowAlarmLimit, authSuccess, antennaDriversOff;
   logic hostFilterHighspeedForce, cardCipherActive;
   logic [6:0] fifoByteCount;
   logic [2:0] txrxStateCode;
   int badCount = 0;
   int checks = 0;
   int cycles = 0;
   int cnt[4] = '{4, 5, 59, 60};
   rsr_status_regs i_dut (.*);
   // Clock and hang guard
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         badCount++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      if (badCount == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer, held until ready is sampled high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, {24'h0, e})
   endtask
   task settle();
      repeat (5) @(posedge clock);
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {crcBusy, crcResultZero, crcStandaloneDone, crcStandaloneStart} = '0;
      {irqSources, irqEnables, timerCounting, timerGatedMode} = '0;
      {timerGateEnabled, fifoByteCount, overheatDetect} = '0;
      {belowAlarmLimit, authSuccess, txrxStateCode} = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      settle();
      rdchk(12'h01C, 8'h21);
      rdchk(12'h020, 8'h00);
      xfer(1'b0, 12'h100, 32'h0);
      `CHK(err, 1'b1)
      crcStandaloneStart <= 1'b1;
      crcBusy <= 1'b1;
      crcResultZero <= 1'b1;
      @(posedge clock);
      crcStandaloneStart <= 1'b0;
      settle();
      rdchk(12'h01C, 8'h01);
      crcBusy <= 1'b0;
      crcStandaloneDone <= 1'b1;
      @(posedge clock);
      crcStandaloneDone <= 1'b0;
      settle();
      rdchk(12'h01C, 8'h61);
      rdchk(12'h01C, 8'h61);
      crcResultZero <= 1'b0;
      irqSources <= 14'h0004;
      settle();
      rdchk(12'h01C, 8'h21);
      irqEnables <= 14'h0004;
      settle();
      rdchk(12'h01C, 8'h31);
      irqSources <= 14'h0;
      timerCounting <= 1'b1;
      settle();
      rdchk(12'h01C, 8'h29);
      timerCounting <= 1'b0;
      timerGatedMode <= 1'b1;
      timerGateEnabled <= 1'b1;
      settle();
      rdchk(12'h01C, 8'h29);
      timerGatedMode <= 1'b0;
      xfer(1'b1, 12'h048, 32'h4);
      foreach (cnt[i]) begin
         fifoByteCount <= 7'(cnt[i]);
         settle();
         rdchk(12'h01C, {6'h08, 7'd64 - 7'(cnt[i]) <= 7'd4,
            7'(cnt[i]) <= 7'd4});
      end
      fifoByteCount <= 7'd20;
      for (int s = 0; s < 7; s++) begin
         txrxStateCode <= 3'(s);
         settle();
         rdchk(12'h020, {5'h0, 3'(s)});
      end
      txrxStateCode <= 3'h0;
      xfer(1'b1, 12'h020, 32'h40);
      settle();
      `CHK(hostFilterHighspeedForce, 1'b1)
      authSuccess <= 1'b1;
      @(posedge clock);
      authSuccess <= 1'b0;
      settle();
      rdchk(12'h020, 8'h48);
      xfer(1'b1, 12'h020, 32'h40);
      settle();
      `CHK(cardCipherActive, 1'b0)
      overheatDetect <= 1'b1;
      settle();
      `CHK(antennaDriversOff, 1'b1)
      overheatDetect <= 1'b0;
      xfer(1'b1, 12'h020, 32'hC0);
      settle();
      `CHK(antennaDriversOff, 1'b1)
      belowAlarmLimit <= 1'b1;
      settle();
      xfer(1'b1, 12'h020, 32'hC0);
      settle();
      `CHK(antennaDriversOff, 1'b0)
      xfer(1'b1, 12'h044, 32'h0);
      xfer(1'b1, 12'h040, 32'hF);
      rdchk(12'h040, 8'h00);
      // A fresh command clears the done flag so its finish is an edge
      crcStandaloneStart <= 1'b1;
      @(posedge clock);
      crcStandaloneStart <= 1'b0;
      crcStandaloneDone <= 1'b1;
      @(posedge clock);
      crcStandaloneDone <= 1'b0;
      settle();
      rdchk(12'h040, 8'h01);
      `CHK(irq, 1'b0)
      xfer(1'b1, 12'h044, 32'h1);
      settle();
      `CHK(irq, 1'b1)
      xfer(1'b1, 12'h040, 32'h1);
      settle();
      `CHK(irq, 1'b0)
      tally_and_finish();
   end
endmodule
bind rsr_status_regs rsr_status_regs_assertions i_chk (.*);
